// file: hw/cief_pkg.sv
// constants for the can event flag, enable and error count block
// assumes a 16-bit register port and a protocol engine on core_clk
package cief_pkg;
  // register word offsets on the register port
  localparam logic [1:0] OFS_FLAGS  = 2'h0;
  localparam logic [1:0] OFS_ENABLE = 2'h1;
  localparam logic [1:0] OFS_COUNT  = 2'h2;
  // fault state field positions
  localparam int BIT_TX_BUS_OFF = 13;
  localparam int BIT_TX_PASSIVE = 12;
  localparam int BIT_RX_PASSIVE = 11;
  localparam int BIT_TX_WARNING = 10;
  localparam int BIT_RX_WARNING = 9;
  localparam int BIT_ANY_WARNING = 8;
  // event flag positions
  localparam int BIT_INVALID_MSG = 7;
  localparam int BIT_WAKEUP      = 6;
  localparam int BIT_ERROR       = 5;
  localparam int BIT_FIFO_FULL   = 3;
  localparam int BIT_RX_OVERFLOW = 2;
  localparam int BIT_RX_BUFFER   = 1;
  localparam int BIT_TX_BUFFER   = 0;
  // implemented event bits, bit 4 absent
  localparam logic [7:0] EVENT_MASK = 8'hEF;
  // reset values
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [5:0] FAULT_RST  = 6'h00;
  localparam logic [8:0] COUNT_RST  = 9'h000;
  // fault confinement thresholds
  localparam logic [8:0] WARN_LEVEL    = 9'h060;
  localparam logic [8:0] PASSIVE_LEVEL = 9'h080;
  localparam logic [8:0] BUS_OFF_ABOVE = 9'h0FF;
endpackage : cief_pkg

// file: hw/cief_fault_state.sv
// fault confinement state decode from the two error counters
// assumes counts come from logic on core_clk
`timescale 1ns/10ps
module cief_fault_state (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // counters from the protocol engine
  input  wire logic [8:0] tx_count,
  input  wire logic [8:0] rx_count,
  // state bits 13..8 in order, and entry pulse
  output logic      [5:0] fault_r,
  output logic            enter_r
);
  logic [5:0] fault_nxt; // decoded state
  logic       enter_nxt; // any bit newly set

  // decode thresholds; bus-off sits above the passive band
  always_comb begin
    fault_nxt[5] = tx_count > cief_pkg::BUS_OFF_ABOVE;
    fault_nxt[4] = (tx_count >= cief_pkg::PASSIVE_LEVEL) && !fault_nxt[5];
    fault_nxt[3] = rx_count >= cief_pkg::PASSIVE_LEVEL;
    fault_nxt[2] = tx_count >= cief_pkg::WARN_LEVEL;
    fault_nxt[1] = rx_count >= cief_pkg::WARN_LEVEL;
    fault_nxt[0] = fault_nxt[2] | fault_nxt[1];
    enter_nxt    = |(fault_nxt & ~fault_r);
  end

  // register the state so it lines up with the count copy
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_r <= cief_pkg::FAULT_RST;
      enter_r <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
      enter_r <= enter_nxt;
    end
  end
endmodule // cief_fault_state

// file: hw/cief_event_flag.sv
// sticky event flags, cleared by software writing zero
// assumes set pulses come from logic on core_clk
`timescale 1ns/10ps
module cief_event_flag #(
  parameter int          W    = 8,
  parameter logic [15:0] MASK = 16'h00EF
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // hardware set pulses
  input  wire logic [W-1:0] set_vec,
  // software clear write
  input  wire logic         clr_wr,
  input  wire logic [W-1:0] clr_data,
  // flags
  output logic      [W-1:0] flag_r
);
  logic [W-1:0] flag_nxt; // next flags
  logic [W-1:0] keep;     // bits not cleared

  // width beyond the register word cannot be served
  if (W < 1 || W > 16) begin : g_chk
    $error("cief_event_flag width out of range");
  end

  // a zero clears, a one keeps; set wins over clear
  always_comb begin
    keep     = clr_wr ? clr_data : {W{1'b1}};
    flag_nxt = ((flag_r & keep) | set_vec) & MASK[W-1:0];
  end

  // registers only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end
endmodule // cief_event_flag

// file: hw/cief_top.sv
// can event flag, enable and error count registers
// assumes the protocol engine and register port share core_clk
`timescale 1ns/10ps
module cief_top (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [1:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // error counters from the protocol engine
  input  wire logic [8:0]  tx_err_count,
  input  wire logic [7:0]  rx_err_count,
  // one-cycle event pulses from the protocol engine
  input  wire logic        invalid_msg_evt,
  input  wire logic        wakeup_evt,
  input  wire logic        fifo_almost_full_evt,
  input  wire logic        rx_overflow_evt,
  input  wire logic        rx_buffer_evt,
  input  wire logic        tx_buffer_evt,
  // module interrupt request
  output logic             irq
);

  // saturate a 9-bit count into the 8-bit field
  function automatic logic [7:0] sat8(input logic [8:0] v);
    sat8 = v[8] ? 8'hFF : v[7:0];
  endfunction

  // ---- count copies -------------------------------------------
  logic [8:0] tx_cnt_r;   // transmit count copy
  logic [8:0] tx_cnt_nxt; // next copy
  logic [8:0] rx_cnt_r;   // receive count copy, 9 bits for the decode checks
  logic [8:0] rx_cnt_nxt; // next copy

  // counts are sampled every cycle so the field tracks the engine
  always_comb begin
    tx_cnt_nxt = tx_err_count;
    rx_cnt_nxt = {1'b0, rx_err_count};
  end

  // registers only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_cnt_r <= cief_pkg::COUNT_RST;
      rx_cnt_r <= cief_pkg::COUNT_RST;
    end else begin
      tx_cnt_r <= tx_cnt_nxt;
      rx_cnt_r <= rx_cnt_nxt;
    end
  end

  // ---- fault state --------------------------------------------
  logic [5:0] fault;       // status bits 13..8
  logic       fault_enter; // some state bit newly entered

  // decode from the raw counts, so state and copy change together
  cief_fault_state u_fault (
    .core_clk (core_clk),
    .rst      (rst),
    .tx_count (tx_err_count),
    .rx_count ({1'b0, rx_err_count}),
    .fault_r  (fault),
    .enter_r  (fault_enter)
  );

  // ---- decode of the register port ----------------------------
  logic wr_flags;  // write to flag register
  logic wr_enable; // write to enable register

  // only these two words take writes; the count word is read-only
  always_comb begin
    wr_flags  = reg_wr && (reg_addr == cief_pkg::OFS_FLAGS);
    wr_enable = reg_wr && (reg_addr == cief_pkg::OFS_ENABLE);
  end

  // ---- event flags --------------------------------------------
  logic [7:0] set_vec; // set pulses by position
  logic [7:0] flags;   // sticky flags

  // gather sources into flag positions; bit 4 never sets
  always_comb begin
    set_vec = 8'h00;
    set_vec[cief_pkg::BIT_INVALID_MSG] = invalid_msg_evt;
    set_vec[cief_pkg::BIT_WAKEUP]      = wakeup_evt;
    set_vec[cief_pkg::BIT_ERROR]       = fault_enter;
    set_vec[cief_pkg::BIT_FIFO_FULL]   = fifo_almost_full_evt;
    set_vec[cief_pkg::BIT_RX_OVERFLOW] = rx_overflow_evt;
    set_vec[cief_pkg::BIT_RX_BUFFER]   = rx_buffer_evt;
    set_vec[cief_pkg::BIT_TX_BUFFER]   = tx_buffer_evt;
  end

  // writes of one are harmless, so one flag clears by writing zero there and ones elsewhere
  cief_event_flag #(
    .W    (8),
    .MASK ({8'h00, cief_pkg::EVENT_MASK})
  ) u_flags (
    .core_clk (core_clk),
    .rst      (rst),
    .set_vec  (set_vec),
    .clr_wr   (wr_flags),
    .clr_data (reg_wdata[7:0]),
    .flag_r   (flags)
  );

  // ---- enables ------------------------------------------------
  logic [7:0] enable_r;   // enable bits
  logic [7:0] enable_nxt; // next enables

  // plain read/write; bit 4 held at zero
  always_comb begin
    enable_nxt = enable_r;
    if (wr_enable) begin
      enable_nxt = reg_wdata[7:0] & cief_pkg::EVENT_MASK;
    end
  end

  // registers only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enable_r <= cief_pkg::ENABLE_RST;
    end else begin
      enable_r <= enable_nxt;
    end
  end

  // ---- interrupt request --------------------------------------
  logic irq_nxt; // any enabled flag

  // level request; it falls one cycle after the flag is cleared
  always_comb begin
    irq_nxt = |(flags & enable_r);
  end

  // registers only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_nxt;
    end
  end

  // ---- read data ----------------------------------------------
  logic [15:0] rdata_nxt; // selected word

  // read data stand for one cycle only, zero otherwise;
  // unmapped words read zero rather than aliasing
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        cief_pkg::OFS_FLAGS: begin
          // bits 15-14 and 4 stay zero
          rdata_nxt = {2'b00, fault, flags & cief_pkg::EVENT_MASK};
        end
        cief_pkg::OFS_ENABLE: begin
          // upper byte unimplemented
          rdata_nxt = {8'h00, enable_r};
        end
        cief_pkg::OFS_COUNT: begin
          // transmit count above 255 shows as full scale
          rdata_nxt = {sat8(tx_cnt_r), rx_cnt_r[7:0]};
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end
  end

  // registers only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ---- checks -------------------------------------------------
  property p_bus_off;
    @(posedge core_clk) disable iff (rst)
      fault[5] == (tx_cnt_r > 9'h0FF);
  endproperty
  a_bus_off: assert property (p_bus_off)
    else $error("bus-off bit disagrees with tx count");

  property p_tx_passive;
    @(posedge core_clk) disable iff (rst)
      fault[4] == ((tx_cnt_r >= 9'h080) && (tx_cnt_r <= 9'h0FF));
  endproperty
  a_tx_passive: assert property (p_tx_passive)
    else $error("tx passive bit disagrees with tx count");

  property p_rx_passive;
    @(posedge core_clk) disable iff (rst)
      fault[3] == (rx_cnt_r >= 9'h080);
  endproperty
  a_rx_passive: assert property (p_rx_passive)
    else $error("rx passive bit disagrees with rx count");

  property p_tx_warn;
    @(posedge core_clk) disable iff (rst)
      fault[2] == (tx_cnt_r >= 9'h060);
  endproperty
  a_tx_warn: assert property (p_tx_warn)
    else $error("tx warning bit disagrees with tx count");

  property p_rx_warn;
    @(posedge core_clk) disable iff (rst)
      fault[1] == (rx_cnt_r >= 9'h060);
  endproperty
  a_rx_warn: assert property (p_rx_warn)
    else $error("rx warning bit disagrees with rx count");

  property p_any_warn;
    @(posedge core_clk) disable iff (rst)
      fault[0] == (fault[2] | fault[1]);
  endproperty
  a_any_warn: assert property (p_any_warn)
    else $error("combined warning is not the OR");

  property p_invalid_set;
    @(posedge core_clk) disable iff (rst)
      invalid_msg_evt |=> flags[7];
  endproperty
  a_invalid_set: assert property (p_invalid_set)
    else $error("invalid message flag not set");

  property p_tx_buf_set;
    @(posedge core_clk) disable iff (rst)
      tx_buffer_evt |=> flags[0];
  endproperty
  a_tx_buf_set: assert property (p_tx_buf_set)
    else $error("tx buffer flag not set");

  property p_error_set;
    @(posedge core_clk) disable iff (rst)
      (|(fault & ~$past(fault))) |-> ##1 flags[5];
  endproperty
  a_error_set: assert property (p_error_set)
    else $error("error flag missed a fault state entry");

  property p_write_one_keeps;
    @(posedge core_clk) disable iff (rst)
      (wr_flags && !flags[1] && !rx_buffer_evt) |=> !flags[1];
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps)
    else $error("flag set by a software write");

  property p_enable_wr;
    @(posedge core_clk) disable iff (rst)
      wr_enable |=> enable_r == ($past(reg_wdata[7:0]) & 8'hEF);
  endproperty
  a_enable_wr: assert property (p_enable_wr)
    else $error("enable write not stored");

  property p_flag_unimpl;
    @(posedge core_clk) disable iff (rst)
      (reg_rd && reg_addr == 2'h0) |=> (reg_rdata[15:14] == 2'b00 && !reg_rdata[4]);
  endproperty
  a_flag_unimpl: assert property (p_flag_unimpl)
    else $error("unimplemented flag bits read nonzero");

  property p_count_read;
    @(posedge core_clk) disable iff (rst)
      (reg_rd && reg_addr == 2'h2) |=> reg_rdata[7:0] == $past(rx_cnt_r[7:0]);
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("rx count field wrong");

  property p_irq;
    @(posedge core_clk) disable iff (rst)
      ##1 irq == $past(|(flags & enable_r));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request does not follow flags and enables");

  // the remaining sources, so that a miswired set position cannot hide
  property p_wakeup_set;
    @(posedge core_clk) disable iff (rst)
      wakeup_evt |=> flags[cief_pkg::BIT_WAKEUP];
  endproperty
  a_wakeup_set: assert property (p_wakeup_set)
    else $error("wake-up flag not set");

  property p_fifo_set;
    @(posedge core_clk) disable iff (rst)
      fifo_almost_full_evt |=> flags[cief_pkg::BIT_FIFO_FULL];
  endproperty
  a_fifo_set: assert property (p_fifo_set)
    else $error("fifo almost full flag not set");

  property p_rx_ovf_set;
    @(posedge core_clk) disable iff (rst)
      rx_overflow_evt |=> flags[cief_pkg::BIT_RX_OVERFLOW];
  endproperty
  a_rx_ovf_set: assert property (p_rx_ovf_set)
    else $error("rx overflow flag not set");

  property p_rx_buf_set;
    @(posedge core_clk) disable iff (rst)
      rx_buffer_evt |=> flags[cief_pkg::BIT_RX_BUFFER];
  endproperty
  a_rx_buf_set: assert property (p_rx_buf_set)
    else $error("rx buffer flag not set");

  // a zero written clears unless the event lands in the same cycle
  property p_zero_clears;
    @(posedge core_clk) disable iff (rst)
      (wr_flags && !reg_wdata[cief_pkg::BIT_TX_BUFFER] && !tx_buffer_evt) |=> !flags[cief_pkg::BIT_TX_BUFFER];
  endproperty
  a_zero_clears: assert property (p_zero_clears)
    else $error("zero write did not clear the flag");

  // without a register write a flag never falls by itself
  property p_flag_hold;
    @(posedge core_clk) disable iff (rst)
      (flags[cief_pkg::BIT_INVALID_MSG] && !wr_flags) |=> flags[cief_pkg::BIT_INVALID_MSG];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag fell without a software write");

  property p_enable_unimpl;
    @(posedge core_clk) disable iff (rst)
      (reg_rd && reg_addr == cief_pkg::OFS_ENABLE) |=> (reg_rdata[15:8] == 8'h00 && !reg_rdata[4]);
  endproperty
  a_enable_unimpl: assert property (p_enable_unimpl)
    else $error("unimplemented enable bits read nonzero");

  // transmit field shows full scale once the count passes 255
  property p_tx_count_read;
    @(posedge core_clk) disable iff (rst)
      (reg_rd && reg_addr == cief_pkg::OFS_COUNT) |=>
        reg_rdata[15:8] == ($past(tx_cnt_r[8]) ? 8'hFF : $past(tx_cnt_r[7:0]));
  endproperty
  a_tx_count_read: assert property (p_tx_count_read)
    else $error("tx count field wrong");

  property p_status_read;
    @(posedge core_clk) disable iff (rst)
      (reg_rd && reg_addr == cief_pkg::OFS_FLAGS) |=> reg_rdata[13:8] == $past(fault);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status bits in the flag word disagree with the state");

endmodule // cief_top

// file: testbench/cief_top_tb.sv
// self-checking bench for the can event flag, enable and error count block
// assumes one core_clk domain; the bench drives register port and engine inputs
`timescale 1ns/10ps
module cief_top_tb;
  // one row of the count table: counts in, status and count word out
  typedef struct {
    logic [8:0]  tx;
    logic [7:0]  rx;
    logic [5:0]  stat;
    logic [15:0] cnt;
  } cief_row_s;

  logic        core_clk;      // 100 MHz clock
  logic        rst;           // async reset, active high
  logic [1:0]  reg_addr;      // word select
  logic [15:0] reg_wdata;     // write data
  logic        reg_wr;        // write strobe
  logic        reg_rd;        // read strobe
  logic [15:0] reg_rdata;     // read data
  logic [8:0]  tx_err_count;  // engine tx count
  logic [7:0]  rx_err_count;  // engine rx count
  logic [5:0]  evt;           // event pulses, invalid..tx buffer
  logic        irq;           // interrupt request
  logic [15:0] rdv;           // last read value
  int          miscompares;   // mismatches seen
  int          n_compared;    // comparisons made
  int          bitpos [6] = '{7, 6, 3, 2, 1, 0};  // flag bit of each event

  // thresholds at both edges of warning and bus-off, passive at its lower edge only, and the tx saturation above 255
  cief_row_s rows [9] = '{
    '{9'h000, 8'h00, 6'h00, 16'h0000},
    '{9'h05F, 8'h5F, 6'h00, 16'h5F5F},
    '{9'h060, 8'h00, 6'h05, 16'h6000},
    '{9'h000, 8'h60, 6'h03, 16'h0060},
    '{9'h080, 8'h00, 6'h15, 16'h8000},
    '{9'h000, 8'h80, 6'h0B, 16'h0080},
    '{9'h0FF, 8'hFF, 6'h1F, 16'hFFFF},
    '{9'h100, 8'h00, 6'h25, 16'hFF00},
    '{9'h12C, 8'hC8, 6'h2F, 16'hFFC8}};

  cief_top u_dut (
    .core_clk             (core_clk),
    .rst                  (rst),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .tx_err_count         (tx_err_count),
    .rx_err_count         (rx_err_count),
    .invalid_msg_evt      (evt[5]),
    .wakeup_evt           (evt[4]),
    .fifo_almost_full_evt (evt[3]),
    .rx_overflow_evt      (evt[2]),
    .rx_buffer_evt        (evt[1]),
    .tx_buffer_evt        (evt[0]),
    .irq                  (irq)
  );

  // free-running clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // compare and count
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  // one-cycle write
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // one-cycle read, data taken in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    rdv = reg_rdata;
  endtask

  // one-cycle event pulse on input k
  task automatic pulse(input int k);
    @(posedge core_clk);
    evt[k] <= 1'b1;
    @(posedge core_clk);
    evt[k] <= 1'b0;
  endtask

  // new counts, then let status settle
  task automatic counts(input logic [8:0] t, input logic [7:0] r);
    @(posedge core_clk);
    tx_err_count <= t;
    rx_err_count <= r;
    repeat (3) @(posedge core_clk);
  endtask

  // verdict and end of run
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    results();
  end

  // main sequence
  initial begin
    rst          = 1'b1;
    reg_addr     = 2'h0;
    reg_wdata    = 16'h0000;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    tx_err_count = 9'h000;
    rx_err_count = 8'h00;
    evt          = 6'h00;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a < 3; a++) begin
      rd(a[1:0]);
      chk("reset word", 16'h0000, rdv);
    end
    $display("test reset done");
    // table: status bits and counter fields
    foreach (rows[i]) begin
      counts(rows[i].tx, rows[i].rx);
      rd(cief_pkg::OFS_FLAGS);
      chk("status", {2'b00, rows[i].stat, 8'h00}, rdv & 16'hFF00);
      rd(cief_pkg::OFS_COUNT);
      chk("counts", rows[i].cnt, rdv);
    end
    $display("test count table done");
    // error flag on entry to a fault state, not on the held level
    counts(9'h000, 8'h00);
    wr(cief_pkg::OFS_FLAGS, 16'h0000);
    rd(cief_pkg::OFS_FLAGS);
    chk("flags cleared", 16'h0000, rdv);
    counts(9'h060, 8'h00);
    rd(cief_pkg::OFS_FLAGS);
    chk("error flag", 16'h0520, rdv);
    wr(cief_pkg::OFS_FLAGS, 16'hFFDF);
    rd(cief_pkg::OFS_FLAGS);
    chk("error cleared", 16'h0500, rdv);
    counts(9'h000, 8'h00);
    $display("test error flag done");
    // enable register: seven bits, upper byte and bit 4 read zero
    wr(cief_pkg::OFS_ENABLE, 16'hFFFF);
    rd(cief_pkg::OFS_ENABLE);
    chk("enables", 16'h00EF, rdv);
    wr(cief_pkg::OFS_FLAGS, 16'h0000);
    $display("test enables done");
    // each event: masked, then enabled, then write-one, then write-zero
    for (int k = 0; k < 6; k++) begin
      wr(cief_pkg::OFS_ENABLE, 16'h0001 << bitpos[(k + 1) % 6]);
      pulse(5 - k);
      @(posedge core_clk);
      #1;
      chk("irq masked", 16'h0000, {15'h0000, irq});
      wr(cief_pkg::OFS_ENABLE, 16'h0001 << bitpos[k]);
      @(posedge core_clk);
      #1;
      chk("irq", 16'h0001, {15'h0000, irq});
      wr(cief_pkg::OFS_FLAGS, 16'hFFFF);
      rd(cief_pkg::OFS_FLAGS);
      chk("event flag", 16'h0001 << bitpos[k], rdv);
      wr(cief_pkg::OFS_FLAGS, ~(16'h0001 << bitpos[k]));
      rd(cief_pkg::OFS_FLAGS);
      chk("flag cleared", 16'h0000, rdv);
      chk("irq low", 16'h0000, {15'h0000, irq});
    end
    $display("test events done");
    // set and zero-write in the same cycle: set wins
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= cief_pkg::OFS_FLAGS;
    reg_wdata <= 16'h0000;
    evt[0]    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    evt[0]    <= 1'b0;
    rd(cief_pkg::OFS_FLAGS);
    chk("set wins", 16'h0001, rdv);
    $display("test set and clear done");
    // count word read-only, unmapped word reads zero, data stands one cycle
    counts(9'h010, 8'h22);
    wr(cief_pkg::OFS_COUNT, 16'hFFFF);
    wr(2'h3, 16'hFFFF);
    rd(2'h3);
    chk("unmapped", 16'h0000, rdv);
    rd(cief_pkg::OFS_COUNT);
    chk("counts ro", 16'h1022, rdv);
    @(posedge core_clk);
    #1;
    chk("rdata idle", 16'h0000, reg_rdata);
    $display("test read-only done");
    // reset in mid-run with a flag and an enable set
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk("irq reset", 16'h0000, {15'h0000, irq});
    rd(cief_pkg::OFS_FLAGS);
    chk("flags reset", 16'h0000, rdv);
    rd(cief_pkg::OFS_ENABLE);
    chk("enables reset", 16'h0000, rdv);
    $display("test mid-run reset done");
    results();
  end
endmodule // cief_top_tb
